//--- rtl/pin_config_pkg.sv
// Constants, field layout and helpers for the upper port-1 pin configuration block
// Operation
// R1: Nine 32-bit config registers, four-byte stride
// R2: Bits 2:0 select GPIO or peripheral
// R3: Bits 4:3 select none, down, up, keeper
// R4: Pull field resets to pull-up
// R5: Bit 6 inverts the input path
// R6: Bit 8 bypasses glitch filter, resets set
// R7: Bit 9 selects fast slew, reset slow
// R8: Bit 10 selects simulated open-drain output
// R9: Software writes zero to reserved bits
// R10: Bit 7 clear blocks digital input path
// R11: Unassigned function code leaves driver off
package pin_config_pkg;
  localparam int          PIN_COUNT     = 9;        // Pins 9 through 17 of port 1
  localparam int          CFG_ADR_W     = 12;       // Byte address width of the block
  localparam int          CFG_W         = 11;       // Implemented bits per register
  localparam logic [11:0] CFG_BASE      = 12'h0a4;  // First register, pin 9
  localparam logic [11:0] CFG_LAST      = 12'h0c4;  // Last register, pin 17
  localparam logic [11:0] CFG_STRIDE    = 12'h004;  // Byte step between registers
  // Field positions
  localparam int          FUNCTION_SELECT_LSB      = 0;
  localparam int          PULL_LSB      = 3;
  localparam int          INVERT_BIT    = 6;
  localparam int          DIGITAL_BIT   = 7;
  localparam int          BYPASS_BIT    = 8;
  localparam int          SLEW_BIT      = 9;
  localparam int          OD_BIT        = 10;
  // Reset: pull-up, digital, filter bypassed, all else zero
  localparam logic [10:0] CFG_RESET     = 11'h190;
  // Writable bits; bit 5 is reserved
  localparam logic [10:0] CFG_WMASK     = 11'h7df;
  // Function codes
  localparam logic [2:0]  FUNCTION_SELECT_GPIO     = 3'h0;
  localparam logic [2:0]  FUNCTION_SELECT_ALT_A    = 3'h2;
  localparam logic [2:0]  FUNCTION_SELECT_ALT_B    = 3'h3;
  localparam logic [2:0]  FUNCTION_SELECT_ALT_C    = 3'h4;
  localparam int          ALT_SLOTS     = 3;
  localparam logic [1:0]  SLOT_NONE     = 2'h3;
  // Pull codes
  localparam logic [1:0]  PULL_NONE     = 2'h0;
  localparam logic [1:0]  PULL_DOWN     = 2'h1;
  localparam logic [1:0]  PULL_UP       = 2'h2;
  localparam logic [1:0]  PULL_KEEPER   = 2'h3;
  // Peripheral slots present per pin, bit 0 = code 2, index 0 = pin 9
  localparam logic [PIN_COUNT-1:0][2:0] FUNCTION_SELECT_AVAIL =
    {3'h0, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h3, 3'h3, 3'h3};
  // Glitch filter timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          FILTER_NS     = 10;
  localparam int          FILTER_CYC_RAW = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FILTER_CYCLES = (FILTER_CYC_RAW < 1) ? 1 : FILTER_CYC_RAW;

  // Address falls on a configuration register
  function automatic logic cfg_hit(input logic [CFG_ADR_W-1:0] adr);
    return (adr >= CFG_BASE) && (adr <= CFG_LAST) && (adr[1:0] == 2'h0);
  endfunction : cfg_hit

  // Register index from byte address
  function automatic logic [3:0] cfg_index(input logic [CFG_ADR_W-1:0] adr);
    logic [11:0] off;
    off = (adr - CFG_BASE) / CFG_STRIDE;
    return off[3:0];
  endfunction : cfg_index

  // Peripheral slot of a function code, SLOT_NONE if none
  function automatic logic [1:0] alt_slot(input logic [2:0] function_select);
    case (function_select)
      FUNCTION_SELECT_ALT_A: alt_slot = 2'h0;
      FUNCTION_SELECT_ALT_B: alt_slot = 2'h1;
      FUNCTION_SELECT_ALT_C: alt_slot = 2'h2;
      default:    alt_slot = SLOT_NONE;
    endcase
  endfunction : alt_slot
endpackage : pin_config_pkg

//--- rtl/pad_ctrl_if.sv
// Per-pin control bundle from the configuration core to a pad driver
`timescale 1ns/100ps
interface pad_ctrl_if;
  logic       drive_val;   // Value the selected function drives
  logic       drive_en;    // Selected function wants the pin driven
  logic [1:0] pull;        // Pull field
  logic       fast_slew;   // Slew limiting off
  logic       open_drain;  // Simulated open-drain
  logic       digital;     // Digital mode
  modport ctrl (output drive_val, drive_en, pull, fast_slew, open_drain, digital);
  modport pad  (input  drive_val, drive_en, pull, fast_slew, open_drain, digital);
endinterface : pad_ctrl_if

//--- rtl/glitch_filter.sv
// Input glitch filter with bypass for one pad
`timescale 1ns/100ps
module glitch_filter import pin_config_pkg::*; #(
  parameter int FILT_CYCLES = FILTER_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic raw,
  input  wire logic bypass,
  output logic      filt
);
  localparam int CW = $clog2(FILT_CYCLES + 1);
  localparam logic [CW-1:0] FILT_MAX = CW'(FILT_CYCLES);

  logic          sample_ff;   // Previous raw sample
  logic [CW-1:0] stable_ff;   // Cycles raw has matched the sample
  logic          out_ff;      // Accepted level
  logic          nxt_sample;
  logic [CW-1:0] nxt_stable;
  logic          nxt_out;

  // Next state: accept raw once it has held long enough, or at once when bypassed
  always_comb begin
    nxt_sample = raw;
    nxt_stable = stable_ff;
    nxt_out    = out_ff;
    if (raw != sample_ff) begin
      nxt_stable = '0;
    end else if (stable_ff != FILT_MAX) begin
      nxt_stable = stable_ff + CW'(1);
    end
    if (bypass) begin
      nxt_out = raw;  // see R6
    end else if ((raw == sample_ff) && (stable_ff >= FILT_MAX - CW'(1))) begin
      nxt_out = raw;  // see R6
    end
  end

  // Registers, frozen while clk_en is low
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_ff <= 1'b0;
      stable_ff <= '0;
      out_ff    <= 1'b0;
    end else if (clk_en) begin
      sample_ff <= nxt_sample;
      stable_ff <= nxt_stable;
      out_ff    <= nxt_out;
    end
  end

  assign filt = out_ff;

  // A one-cycle change is not accepted while filtering
  a_filter_holds_glitch: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R6
    (clk_en && !bypass && (raw != sample_ff)) |=> (out_ff == $past(out_ff)))
    else $error("glitch filter passed an unsettled input");
endmodule : glitch_filter

//--- rtl/pad_driver.sv
// Registered pad controls for one pin
`timescale 1ns/100ps
module pad_driver import pin_config_pkg::*; (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  pad_ctrl_if.pad   ctl,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pull_up,
  output logic      pull_down,
  output logic      keeper,
  output logic      fast_slew,
  output logic      analog_en
);
  logic [6:0] pad_ff;    // {out, oe, up, down, keeper, fast, analog}
  logic [6:0] nxt_pad;

  // Decode drive and pull controls
  always_comb begin
    nxt_pad[6] = ctl.open_drain ? 1'b0 : ctl.drive_val;                   // see R8
    nxt_pad[5] = ctl.drive_en && !(ctl.open_drain && ctl.drive_val);      // see R8
    nxt_pad[4] = (ctl.pull == PULL_UP);                                   // see R3
    nxt_pad[3] = (ctl.pull == PULL_DOWN);                                 // see R3
    nxt_pad[2] = (ctl.pull == PULL_KEEPER);                               // see R3
    nxt_pad[1] = ctl.fast_slew;                                           // see R7
    nxt_pad[0] = !ctl.digital;                                            // see R10
  end

  // Pad registers, pull-up from reset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pad_ff <= 7'h10;  // see R4
    end else if (clk_en) begin
      pad_ff <= nxt_pad;
    end
  end

  assign {pad_out, pad_oe, pull_up, pull_down, keeper, fast_slew, analog_en} = pad_ff;
endmodule : pad_driver

//--- rtl/port1_upper_pin_config.sv
// Configuration registers and signal routing for port-1 pins 9 to 17
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
module port1_upper_pin_config import pin_config_pkg::*; (
  input  wire logic                                sys_clk,
  input  wire logic                                sys_rst,
  input  wire logic                                clk_en,
  // Wishbone classic slave
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [CFG_ADR_W-1:0]                wb_adr_i,
  input  wire logic [3:0]                          wb_sel_i,
  input  wire logic [31:0]                         wb_dat_i,
  output logic      [31:0]                         wb_dat_o,
  output logic                                     wb_ack_o,
  // Pad side
  input  wire logic [PIN_COUNT-1:0]                pad_in,
  output logic      [PIN_COUNT-1:0]                pad_out,
  output logic      [PIN_COUNT-1:0]                pad_oe,
  output logic      [PIN_COUNT-1:0]                pad_pull_up,
  output logic      [PIN_COUNT-1:0]                pad_pull_down,
  output logic      [PIN_COUNT-1:0]                pad_keeper,
  output logic      [PIN_COUNT-1:0]                pad_fast_slew,
  output logic      [PIN_COUNT-1:0]                pad_analog_en,
  // GPIO function
  input  wire logic [PIN_COUNT-1:0]                gpio_out,
  input  wire logic [PIN_COUNT-1:0]                gpio_oe,
  output logic      [PIN_COUNT-1:0]                gpio_in,
  // Peripheral functions, slot 0/1/2 = code 2/3/4
  input  wire logic [PIN_COUNT-1:0][ALT_SLOTS-1:0] alt_out,
  input  wire logic [PIN_COUNT-1:0][ALT_SLOTS-1:0] alt_oe,
  output logic      [PIN_COUNT-1:0][ALT_SLOTS-1:0] alt_in
);

  // Register file state
  logic [CFG_W-1:0] cfg_ff [PIN_COUNT];       // Configuration words
  logic [CFG_W-1:0] nxt_cfg [PIN_COUNT];
  logic             ack_ff;                   // Bus acknowledge
  logic             nxt_ack;
  logic [31:0]      rdata_ff;                 // Read data
  logic [31:0]      nxt_rdata;

  // Bus decode
  logic             bus_req;                  // New request waiting for ack
  logic             bus_hit;                  // Address maps to a register
  logic [3:0]       bus_idx;                  // Register index
  logic             wr_fire;                  // Write takes effect this edge
  logic [31:0]      rd_word;                  // Word a read would return

  // Routing
  logic [PIN_COUNT-1:0]                filt;          // Filtered pad inputs
  logic [PIN_COUNT-1:0]                dig_in;        // Inverted and gated input
  logic [PIN_COUNT-1:0]                drv_val;       // Selected output value
  logic [PIN_COUNT-1:0]                drv_en;        // Selected output enable
  logic [PIN_COUNT-1:0]                gpio_in_ff;
  logic [PIN_COUNT-1:0]                nxt_gpio_in;
  logic [PIN_COUNT-1:0][ALT_SLOTS-1:0] alt_in_ff;
  logic [PIN_COUNT-1:0][ALT_SLOTS-1:0] nxt_alt_in;

  // Address decode
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign bus_hit = cfg_hit(wb_adr_i);                      // see R1
  assign bus_idx = cfg_index(wb_adr_i);                    // see R1
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && bus_hit;

  // Read word, unmapped and reserved bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (bus_hit) begin
      rd_word = {21'h00_0000, cfg_ff[bus_idx]};            // see R1
    end
  end

  // Next state of registers and bus answer
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      nxt_cfg[i] = cfg_ff[i];
    end
    nxt_ack   = bus_req;
    nxt_rdata = rdata_ff;
    if (bus_req) begin
      nxt_rdata = wb_we_i ? 32'h0000_0000 : rd_word;
    end
    // Write lands on the acknowledged edge
    if (wr_fire) begin
      // Byte lanes 0 and 1 hold the fields, reserved bits dropped
      if (wb_sel_i[0]) begin
        nxt_cfg[bus_idx][7:0] = wb_dat_i[7:0] & CFG_WMASK[7:0];   // see R9
      end
      if (wb_sel_i[1]) begin
        nxt_cfg[bus_idx][10:8] = wb_dat_i[10:8];
      end
    end
  end

  // Register file and bus answer registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        cfg_ff[i] <= CFG_RESET;                            // see R4
      end
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        cfg_ff[i] <= nxt_cfg[i];
      end
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // Output selection per pin
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      logic [2:0] fn;
      logic [1:0] sl;
      fn = cfg_ff[i][FUNCTION_SELECT_LSB +: 3];
      sl = alt_slot(fn);
      drv_val[i] = 1'b0;
      drv_en[i]  = 1'b0;
      if (fn == FUNCTION_SELECT_GPIO) begin
        drv_val[i] = gpio_out[i];                          // see R2
        drv_en[i]  = gpio_oe[i];                           // see R2
      end else if ((sl != SLOT_NONE) && FUNCTION_SELECT_AVAIL[i][sl]) begin
        drv_val[i] = alt_out[i][sl];                       // see R2
        drv_en[i]  = alt_oe[i][sl];                        // see R2
      end
      // Anything else leaves the driver off, see R11
    end
  end

  // Input path: invert, then block in analog mode
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      dig_in[i] = (filt[i] ^ cfg_ff[i][INVERT_BIT])        // see R5
                  & cfg_ff[i][DIGITAL_BIT];                // see R10
    end
  end

  // Input steering to the selected function only
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      logic [1:0] sl;
      sl = alt_slot(cfg_ff[i][FUNCTION_SELECT_LSB +: 3]);
      nxt_gpio_in[i] = (cfg_ff[i][FUNCTION_SELECT_LSB +: 3] == FUNCTION_SELECT_GPIO) ? dig_in[i] : 1'b0;
      for (int s = 0; s < ALT_SLOTS; s++) begin
        nxt_alt_in[i][s] = (sl == 2'(s)) && FUNCTION_SELECT_AVAIL[i][s] && dig_in[i];  // see R11
      end
    end
  end

  // Input registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpio_in_ff <= '0;
      alt_in_ff  <= '0;
    end else if (clk_en) begin
      gpio_in_ff <= nxt_gpio_in;
      alt_in_ff  <= nxt_alt_in;
    end
  end

  assign gpio_in = gpio_in_ff;
  assign alt_in  = alt_in_ff;

  // Per-pin filter and pad driver
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    pad_ctrl_if pc ();
    assign pc.drive_val  = drv_val[g];
    assign pc.drive_en   = drv_en[g];
    assign pc.pull       = cfg_ff[g][PULL_LSB +: 2];       // see R3
    assign pc.fast_slew  = cfg_ff[g][SLEW_BIT];            // see R7
    assign pc.open_drain = cfg_ff[g][OD_BIT];              // see R8
    assign pc.digital    = cfg_ff[g][DIGITAL_BIT];

    glitch_filter #(
      .FILT_CYCLES (FILTER_CYCLES)
    ) u_filt (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .raw     (pad_in[g]),
      .bypass  (cfg_ff[g][BYPASS_BIT]),                    // see R6
      .filt    (filt[g])
    );

    pad_driver u_pad (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .ctl       (pc.pad),
      .pad_out   (pad_out[g]),
      .pad_oe    (pad_oe[g]),
      .pull_up   (pad_pull_up[g]),
      .pull_down (pad_pull_down[g]),
      .keeper    (pad_keeper[g]),
      .fast_slew (pad_fast_slew[g]),
      .analog_en (pad_analog_en[g])
    );
  end

  // Checks on the bus and on the first and last pin
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Request, then answer one cycle later
  sequence s_bus_req;
    clk_en && bus_req;
  endsequence
  sequence s_gpio_sel;
    clk_en && (cfg_ff[0][FUNCTION_SELECT_LSB +: 3] == FUNCTION_SELECT_GPIO);
  endsequence

  a_read_answer: assert property (s_bus_req |=> wb_ack_o && // see R1
    (wb_dat_o == ($past(wb_we_i) ? 32'h0000_0000 : $past(rd_word))))
    else $error("read answer wrong or late");

  a_gpio_route: assert property ((s_gpio_sel and !cfg_ff[0][OD_BIT]) |=> // see R2
    (pad_out[0] == $past(gpio_out[0])) && (pad_oe[0] == $past(gpio_oe[0])))
    else $error("gpio output not routed to pad");

  a_pull_decode: assert property (clk_en |=> // see R3
    (pad_pull_up[0] == ($past(cfg_ff[0][PULL_LSB +: 2]) == PULL_UP)) &&
    (pad_keeper[0] == ($past(cfg_ff[0][PULL_LSB +: 2]) == PULL_KEEPER)) &&
    (pad_pull_down[0] == ($past(cfg_ff[0][PULL_LSB +: 2]) == PULL_DOWN)))
    else $error("pull controls disagree with pull field");

  a_reset_pullup: assert property (@(posedge sys_clk) // see R4
    $past(sys_rst) |-> (cfg_ff[0][PULL_LSB +: 2] == PULL_UP) &&
    (cfg_ff[PIN_COUNT-1][PULL_LSB +: 2] == PULL_UP) && pad_pull_up[0])
    else $error("pull-up not selected after reset");

  a_invert_path: assert property (s_gpio_sel |=> // see R5
    gpio_in[0] == $past((filt[0] ^ cfg_ff[0][INVERT_BIT]) & cfg_ff[0][DIGITAL_BIT]))
    else $error("gpio input polarity wrong");

  a_slew_follow: assert property (clk_en |=> // see R7
    pad_fast_slew[PIN_COUNT-1] == $past(cfg_ff[PIN_COUNT-1][SLEW_BIT]))
    else $error("slew control not applied");

  a_od_never_high: assert property ((clk_en && cfg_ff[0][OD_BIT]) |=> // see R8
    !(pad_oe[0] && pad_out[0]))
    else $error("open-drain pin driven high");

  a_analog_gate: assert property ((clk_en && !cfg_ff[0][DIGITAL_BIT]) |=> // see R10
    !gpio_in[0] && (alt_in[0] == '0) && pad_analog_en[0])
    else $error("digital input active in analog mode");

  a_no_function_select_off: assert property ((clk_en && // see R11
    (cfg_ff[PIN_COUNT-1][FUNCTION_SELECT_LSB +: 3] != FUNCTION_SELECT_GPIO)) |=> !pad_oe[PIN_COUNT-1])
    else $error("unassigned function drives the pin");
endmodule : port1_upper_pin_config

//--- sim/pad_model.sv
// Pad wire model: resolves each pin from driver, outside source and pulls
`timescale 1ns/100ps
module pad_model import pin_config_pkg::*; (
  input  wire logic                 sys_clk,
  input  wire logic [PIN_COUNT-1:0] pad_out,
  input  wire logic [PIN_COUNT-1:0] pad_oe,
  input  wire logic [PIN_COUNT-1:0] pull_up,
  input  wire logic [PIN_COUNT-1:0] pull_down,
  input  wire logic [PIN_COUNT-1:0] keeper,
  input  wire logic [PIN_COUNT-1:0] ext_val,
  input  wire logic [PIN_COUNT-1:0] ext_en,
  output logic      [PIN_COUNT-1:0] pad_in
);
  logic [PIN_COUNT-1:0] last_ff;  // Wire level one cycle ago

  // Driver wins, then outside source, then pull network
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pull_up[i]) pad_in[i] = 1'b1;
      else if (pull_down[i]) pad_in[i] = 1'b0;
      else if (keeper[i]) pad_in[i] = last_ff[i];
      else pad_in[i] = ~last_ff[i];                   // Floating wire wanders
    end
  end

  // Remember the level for keeper and floating cases
  always_ff @(posedge sys_clk) begin
    last_ff <= pad_in;
  end
endmodule : pad_model

//--- sim/port1_upper_pin_config_tb.sv
// Self-checking bench for the port-1 upper pin configuration block
`timescale 1ns/100ps
module port1_upper_pin_config_tb import pin_config_pkg::*; ;
  logic                                sys_clk = 1'b0;   // 100 MHz clock
  logic                                sys_rst = 1'b1;   // Async reset
  logic                                clk_en  = 1'b1;   // Low only during the freeze check
  logic                                wb_cyc_i = 1'b0;
  logic                                wb_stb_i = 1'b0;
  logic                                wb_we_i  = 1'b0;
  logic [CFG_ADR_W-1:0]                wb_adr_i = 12'h000;
  logic [3:0]                          wb_sel_i = 4'hf;
  logic [31:0]                         wb_dat_i = 32'h0;
  logic [31:0]                         wb_dat_o;
  logic                                wb_ack_o;
  logic [PIN_COUNT-1:0]                pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
  logic [PIN_COUNT-1:0]                pad_keeper, pad_fast_slew, pad_analog_en, gpio_in;
  logic [PIN_COUNT-1:0]                gpio_out = '0;    // GPIO drive value
  logic [PIN_COUNT-1:0]                gpio_oe  = '0;    // GPIO drive enable
  logic [PIN_COUNT-1:0]                ext_val  = '0;    // Outside source level
  logic [PIN_COUNT-1:0]                ext_en   = '0;    // Outside source active
  logic [PIN_COUNT-1:0][ALT_SLOTS-1:0] alt_out = '0;
  logic [PIN_COUNT-1:0][ALT_SLOTS-1:0] alt_oe  = '0;
  logic [PIN_COUNT-1:0][ALT_SLOTS-1:0] alt_in;
  int                                  fail_count = 0;   // Mismatches
  int                                  n_checks   = 0;   // Comparisons
  int                                  cyc_cnt    = 0;   // Timeout counter

  port1_upper_pin_config i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .pad_keeper(pad_keeper), .pad_fast_slew(pad_fast_slew),
    .pad_analog_en(pad_analog_en), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in));

  pad_model i_pad (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up(pad_pull_up), .pull_down(pad_pull_down), .keeper(pad_keeper),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  // Clock generator
  always #5 sys_clk = ~sys_clk;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // Summary and verdict
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [31:0] wd,
                         input logic [3:0] sel, output logic [31:0] rd);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= sel;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_xfer

  // Write one configuration register of a pin
  task automatic cfg_wr(input int pin, input logic [31:0] val);
    logic [31:0] rd;
    wb_xfer(1'b1, 12'h0a4 + 12'(pin * 4), val & 32'h0000_07df, 4'hf, rd);
  endtask : cfg_wr

  // Read a register and compare
  task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb_xfer(1'b0, adr, 32'h0, 4'hf, rd);
    check(rd, exp, "read data");
  endtask : rd_chk

  // Let configuration and pad pipelines land
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle

  // Reset values of every register and the pull-up default
  task automatic t_reset();
    for (int p = 0; p < 9; p++) rd_chk(12'h0a4 + 12'(p * 4), 32'h0000_0190);
    check(32'(pad_pull_up), 32'h1ff, "pull-up after reset");
    check(32'(pad_analog_en | pad_fast_slew | pad_oe), 32'h0, "pad defaults");
  endtask : t_reset

  // Map, stride, implemented bits and unmapped places
  task automatic t_map();
    logic [31:0] wd;
    for (int p = 0; p < 9; p++) begin
      wd = (32'h0000_05c3 + 32'(p) * 32'h0000_0101) & 32'h0000_07df;
      cfg_wr(p, wd);
    end
    for (int p = 0; p < 9; p++) begin
      wd = (32'h0000_05c3 + 32'(p) * 32'h0000_0101) & 32'h0000_07df;
      rd_chk(12'h0a4 + 12'(p * 4), wd);
    end
    rd_chk(12'h0a0, 32'h0);
    rd_chk(12'h0c8, 32'h0);
    rd_chk(12'h0a6, 32'h0);
    // Lane 0 only: low byte written, bits 10:8 kept, pin 9 goes analog
    wb_xfer(1'b1, 12'h0a4, 32'h0000_0710, 4'h1, wd);
    rd_chk(12'h0a4, 32'h0000_0510);
    check(pad_analog_en[0], 1'b1, "lane 0 analog");
  endtask : t_map

  // Pull field decode on pin 11, read back through the wire
  task automatic t_pull();
    logic [2:0] exp [4] = '{3'b000, 3'b010, 3'b100, 3'b001};
    gpio_oe <= '0;
    for (int c = 0; c < 4; c++) begin
      cfg_wr(2, 32'h0000_0180 | 32'(c << 3));
      settle();
      check({pad_pull_up[2], pad_pull_down[2], pad_keeper[2]}, exp[c], "pull decode");
      if (c == 1 || c == 2) check(gpio_in[2], c == 2, "pulled level");
    end
  endtask : t_pull

  // Every function code on pins 9, 12 and 17
  task automatic t_function_select();
    int pins [3] = '{0, 3, 8};
    logic eo;
    logic ev;
    gpio_out <= '0;
    gpio_oe  <= '1;
    alt_out  <= {PIN_COUNT{3'b101}};
    alt_oe   <= '1;
    foreach (pins[k]) begin
      for (int c = 0; c < 8; c++) begin
        cfg_wr(pins[k], 32'h0000_0190 | 32'(c));
        settle();
        eo = (c == 0) || ((c == 2 || c == 3) && pins[k] < 8) || (c == 4 && pins[k] inside {[3:7]});
        ev = (c == 2 || c == 4);
        check(pad_oe[pins[k]], eo, "drive enable");
        if (eo) check(pad_out[pins[k]], ev, "drive value");
      end
    end
  endtask : t_function_select

  // Inversion, peripheral routing and analog mode on pin 10
  task automatic t_input();
    gpio_oe <= '0;
    alt_oe  <= '0;
    ext_en  <= 9'h002;
    ext_val <= 9'h002;
    cfg_wr(1, 32'h0000_0180);
    settle();
    check(gpio_in[1], 1'b1, "plain input");
    cfg_wr(1, 32'h0000_01c0);
    settle();
    check(gpio_in[1], 1'b0, "inverted input");
    cfg_wr(1, 32'h0000_0182);
    settle();
    check({alt_in[1][0], gpio_in[1]}, 2'b10, "peripheral input");
    cfg_wr(1, 32'h0000_0102);
    settle();
    check({alt_in[1][0], pad_analog_en[1]}, 2'b01, "analog mode");
  endtask : t_input

  // Drive a one-cycle pulse on pin 10 and watch the routed input
  task automatic pulse_seen(output logic seen);
    @(posedge sys_clk);
    ext_val[1] <= 1'b1;
    @(posedge sys_clk);
    ext_val[1] <= 1'b0;
    seen = 1'b0;
    repeat (6) @(posedge sys_clk) seen |= (gpio_in[1] === 1'b1);
  endtask : pulse_seen

  // Glitch filter enabled and bypassed
  task automatic t_filter();
    logic seen;
    ext_val <= '0;
    cfg_wr(1, 32'h0000_0080);
    settle();
    pulse_seen(seen);
    check(seen, 1'b0, "filtered pulse");
    ext_val[1] <= 1'b1;
    settle();
    settle();
    check(gpio_in[1], 1'b1, "filtered level");
    ext_val[1] <= 1'b0;
    cfg_wr(1, 32'h0000_0180);
    settle();
    pulse_seen(seen);
    check(seen, 1'b1, "bypassed pulse");
  endtask : t_filter

  // Slew select and simulated open-drain on pin 13
  task automatic t_slew_od();
    gpio_oe[4]  <= 1'b1;
    gpio_out[4] <= 1'b1;
    cfg_wr(4, 32'h0000_0380);
    settle();
    check(pad_fast_slew[4], 1'b1, "fast slew");
    cfg_wr(4, 32'h0000_0580);
    settle();
    check({pad_fast_slew[4], pad_oe[4]}, 2'b00, "open-drain high");
    gpio_out[4] <= 1'b0;
    settle();
    check({pad_oe[4], pad_out[4]}, 2'b10, "open-drain low");
    // Clock enable low freezes the pad registers
    clk_en      <= 1'b0;
    gpio_out[4] <= 1'b1;
    settle();
    check({pad_oe[4], pad_out[4]}, 2'b10, "frozen by clock enable");
    clk_en      <= 1'b1;
  endtask : t_slew_od

  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_map();
    t_pull();
    t_function_select();
    t_input();
    t_filter();
    t_slew_od();
    print_verdict();
  end
endmodule : port1_upper_pin_config_tb
